// File: src/lscl_pkg.sv
// lscl_pkg: shared constants and types for the led channel shift/latch control.
// assumes one system clock domain; all pin inputs arrive asynchronously.
package lscl_pkg;
    localparam int LSCL_CHANNELS = 8;
    localparam int LSCL_SYNC_STAGES = 2;
    localparam int LSCL_FIFO_DEPTH = 16;
    localparam int LSCL_NUM_PINS = 6;
    // bit positions inside the synchronised pin vector
    localparam int LSCL_PIN_SCLK = 0;
    localparam int LSCL_PIN_SDATA = 1;
    localparam int LSCL_PIN_LOAD = 2;
    localparam int LSCL_PIN_BLANK_N = 3;
    localparam int LSCL_PIN_HOT = 4;
    localparam int LSCL_PIN_COOL = 5;
    // clock figures, kept for cycle arithmetic
    localparam int LSCL_CLK_PERIOD_PS = 25000;
    localparam int LSCL_LINK_PERIOD_PS = 200000;
    localparam int LSCL_LINK_CYCLES = LSCL_LINK_PERIOD_PS / LSCL_CLK_PERIOD_PS;
    localparam logic [LSCL_CHANNELS-1:0] LSCL_LATCH_RST = 8'h00;
    localparam logic [LSCL_CHANNELS-1:0] LSCL_SHIFT_RST = 8'h00;
    localparam logic [LSCL_NUM_PINS-1:0] LSCL_PINS_RST = 6'h08;

    // one link event: a rising serial clock edge and/or a load level change
    typedef struct packed {
        logic shift;
        logic data;
        logic load;
    } lscl_event_t;

    typedef enum logic [1:0] {
        LSCL_IDLE = 2'b01,
        LSCL_APPLY = 2'b10
    } lscl_state_t;
endpackage : lscl_pkg

// File: src/lscl_top.sv
// lscl_top: serial shift register, transparent output latch, blanking and
// thermal cutoff gating for eight led current sink channels.
// assumes clock_i at 40 MHz; every other input is asynchronous to it.
//
// Functional notes
// - die above upper threshold forces all eight sink outputs off.
// - outputs return only once die falls below the lower threshold.
// - thermal cutoff and recovery never touch shift register or latch.
// - pwm of 50Hz to 30kHz on active-low blanking dims all channels.
// - each channel switched on or off by its own latch bit.
// - channels conduct only while blanking is low, tracking pwm duty.
// - rising serial clock shifts data in; host sends msb first.
// - latch transparent while load high, holds on load falling edge.
// - blanking high turns outputs off; shifting and latching continue.
// - serial out shows last stage; input bit appears eight clocks later.

`timescale 1ns/1ps

// two-flop synchroniser; the first stage feeds only the second
module lscl_sync
    import lscl_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // next values of both stages
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : lscl_sync

// fifo with valid/ready on both sides; in_ready_o is registered
module lscl_fifo
    import lscl_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] wr_d;
    logic [PW-1:0] rd_q;
    logic [PW-1:0] rd_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic ready_q;
    logic ready_d;
    logic push;
    logic pop;

    // pointers and count; ready drops in the same cycle the array becomes full
    always_comb begin
        push = in_valid_i && ready_q;
        pop = out_valid_o && out_ready_i;
        wr_d = push ? wr_q + PTR_ONE : wr_q;
        rd_d = pop ? rd_q + PTR_ONE : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CNT_ONE;
        end else if (pop && !push) begin
            cnt_d = cnt_q - CNT_ONE;
        end
        ready_d = (cnt_d != FULL_CNT);
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o = ready_q;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
endmodule : lscl_fifo

module lscl_top
    import lscl_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    input wire logic latch_load_i,
    input wire logic blank_n_i,
    input wire logic temp_above_upper_i,
    input wire logic temp_below_lower_i,
    output logic [LSCL_CHANNELS-1:0] led_sink_outputs_o,
    output logic serial_out_o,
    output logic event_ready_o
);
    logic [LSCL_NUM_PINS-1:0] pins_async;
    logic [LSCL_NUM_PINS-1:0] pins;
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic load_prev_q;
    logic load_prev_d;
    logic sclk_rise;
    logic load_change;
    lscl_event_t ev_in;
    lscl_event_t ev_out;
    logic ev_in_valid;
    logic ev_in_ready;
    logic ev_out_valid;
    logic ev_out_ready;
    lscl_state_t state_q;
    lscl_state_t state_d;
    lscl_event_t held_q;
    lscl_event_t held_d;
    logic [LSCL_CHANNELS-1:0] shift_q;
    logic [LSCL_CHANNELS-1:0] shift_d;
    logic [LSCL_CHANNELS-1:0] latch_q;
    logic [LSCL_CHANNELS-1:0] latch_d;
    logic cut_q;
    logic cut_d;
    logic [LSCL_CHANNELS-1:0] sink_q;
    logic [LSCL_CHANNELS-1:0] sink_d;
    logic sout_q;
    logic sout_d;

    // every pin crosses two flops before any logic reads it
    assign pins_async = {temp_below_lower_i, temp_above_upper_i, blank_n_i,
                         latch_load_i, serial_data_i, serial_clock_i};

    lscl_sync #(
        .WIDTH(LSCL_NUM_PINS),
        .RST_VAL(LSCL_PINS_RST)
    ) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i(pins_async),
        .sync_o(pins)
    );

    // edge finding on the sampled serial clock and load level
    always_comb begin
        sclk_prev_d = pins[LSCL_PIN_SCLK];
        load_prev_d = pins[LSCL_PIN_LOAD];
        sclk_rise = pins[LSCL_PIN_SCLK] && !sclk_prev_q;
        load_change = pins[LSCL_PIN_LOAD] != load_prev_q;
        ev_in.shift = sclk_rise;
        ev_in.data = pins[LSCL_PIN_SDATA];
        ev_in.load = pins[LSCL_PIN_LOAD];
        ev_in_valid = sclk_rise || load_change;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_prev_q <= 1'b0;
            load_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            load_prev_q <= load_prev_d;
        end
    end

    // events queue here; with link edges 4 or more cycles apart the two-cycle apply keeps it from filling
    lscl_fifo #(
        .WIDTH($bits(lscl_event_t)),
        .DEPTH(LSCL_FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_valid_i(ev_in_valid),
        .in_ready_o(ev_in_ready),
        .in_data_i(ev_in),
        .out_valid_o(ev_out_valid),
        .out_ready_i(ev_out_ready),
        .out_data_o(ev_out)
    );

    // take an event in idle, apply it to shift register and latch next cycle
    always_comb begin
        state_d = state_q;
        held_d = held_q;
        shift_d = shift_q;
        latch_d = latch_q;
        ev_out_ready = (state_q == LSCL_IDLE);
        case (state_q)
            LSCL_IDLE: begin
                if (ev_out_valid) begin
                    held_d = ev_out;
                    state_d = LSCL_APPLY;
                end
            end
            LSCL_APPLY: begin
                if (held_q.shift) begin
                    shift_d = {shift_q[LSCL_CHANNELS-2:0], held_q.data};
                end
                if (held_q.load) begin
                    latch_d = shift_d;
                end
                state_d = LSCL_IDLE;
            end
            default: begin
                state_d = LSCL_IDLE;
            end
        endcase
    end

    // blanking and temperature never reach these registers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= LSCL_IDLE;
            held_q <= '0;
            shift_q <= LSCL_SHIFT_RST;
            latch_q <= LSCL_LATCH_RST;
        end else begin
            state_q <= state_d;
            held_q <= held_d;
            shift_q <= shift_d;
            latch_q <= latch_d;
        end
    end

    // thermal hysteresis: set above upper, clear only below lower
    always_comb begin
        cut_d = cut_q;
        if (pins[LSCL_PIN_HOT]) begin
            cut_d = 1'b1;
        end else if (pins[LSCL_PIN_COOL]) begin
            cut_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cut_q <= 1'b0;
        end else begin
            cut_q <= cut_d;
        end
    end

    // output gating; runs on clock_i so cutoff needs no serial clock
    always_comb begin
        sink_d = latch_q;
        if (pins[LSCL_PIN_BLANK_N] || cut_d) begin
            sink_d = LSCL_LATCH_RST;
        end
        sout_d = shift_q[LSCL_CHANNELS-1];
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sink_q <= LSCL_LATCH_RST;
            sout_q <= 1'b0;
        end else begin
            sink_q <= sink_d;
            sout_q <= sout_d;
        end
    end

    assign led_sink_outputs_o = sink_q;
    assign serial_out_o = sout_q;
    assign event_ready_o = ev_in_ready; // registered inside the fifo
endmodule : lscl_top

// File: testbench/lscl_top_sva.sv
// lscl_chk: port checks for the led channel shift/latch control.
// assumes pins change on the falling clock edge, link edges >= 4 cycles apart.
`timescale 1ns/1ps
module lscl_chk
    import lscl_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    input wire logic latch_load_i,
    input wire logic blank_n_i,
    input wire logic temp_above_upper_i,
    input wire logic temp_below_lower_i,
    input wire logic [LSCL_CHANNELS-1:0] led_sink_outputs_o,
    input wire logic serial_out_o,
    input wire logic event_ready_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // sync plus register is three samples; four is the least that sees the output
    sequence s_hot; temp_above_upper_i [*4]; endsequence
    sequence s_no_cool; (!temp_below_lower_i) [*4]; endsequence
    sequence s_led_rise; |(led_sink_outputs_o & ~$past(led_sink_outputs_o)); endsequence
    a_hot_cuts_off: assert property (s_hot |-> led_sink_outputs_o == 8'h00)
        else $error("sinks on while hot");
    a_hot_holds_off: assert property (s_hot ##1 s_no_cool |-> led_sink_outputs_o == 8'h00)
        else $error("sinks back before cool");
    a_blank_gates_off: assert property (blank_n_i [*4] |-> led_sink_outputs_o == 8'h00)
        else $error("sinks on while blanked");
    a_rise_needs_blank: assert property (s_led_rise |->
        !$past(blank_n_i, 2) || !$past(blank_n_i, 3) || !$past(blank_n_i, 4))
        else $error("sink rose without enable");
    a_rise_needs_cool: assert property (s_led_rise |-> !$past(temp_above_upper_i, 2)
        || !$past(temp_above_upper_i, 3) || !$past(temp_above_upper_i, 4))
        else $error("sink rose while hot");
    // clocks may run: only a load-high event may copy into the latch
    a_load_low_holds: assert property ((!latch_load_i && $stable(blank_n_i) && $stable(temp_above_upper_i)
        && $stable(temp_below_lower_i)) [*8] |-> $stable(led_sink_outputs_o))
        else $error("latch moved with load low");
    a_sout_needs_clock: assert property ((!serial_clock_i) [*8] |-> $stable(serial_out_o))
        else $error("serial out moved without clock");
    a_ready_when_quiet: assert property ((!serial_clock_i) [*8] |-> event_ready_o)
        else $error("event path stuck full");
endmodule : lscl_chk

bind lscl_top lscl_chk u_chk (.*);

// File: testbench/lscl_host.sv
// lscl_host: microcontroller model driving the serial channel pins.
// assumes the bench clock; pins move on its falling edge.
`timescale 1ns/1ps
module lscl_host (
    input wire logic clock_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic load_o
);
    initial {sclk_o, sdata_o, load_o} = 3'b000;
    // half of the 200 ns link period
    task automatic half;
        repeat (4) @(negedge clock_i);
    endtask : half
    // msb first; clock stands still between frames
    task automatic send(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            sdata_o = w[i];
            half();
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        sdata_o = ~w[0]; // released line must not look stable
    endtask : send
    task automatic load_pulse;
        load_o = 1'b1;
        half();
        load_o = 1'b0;
        half();
    endtask : load_pulse
    // stand-alone wiring holds load high
    task automatic hold_load(input logic v);
        load_o = v;
    endtask : hold_load
endmodule : lscl_host

// File: testbench/tb_top.sv
// tb_top: self-checking bench for the led channel shift/latch control.
// assumes the host model owns the serial pins; bench owns the rest.
`timescale 1ns/1ps
module tb_top;
    import lscl_pkg::*;
    logic clk;
    logic rst_n;
    logic blank_n;
    logic hot;
    logic cool;
    logic sclk, sdata, load, sout, rdy;
    logic [LSCL_CHANNELS-1:0] led;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    lscl_host host (.clock_i(clk), .sclk_o(sclk), .sdata_o(sdata), .load_o(load));
    lscl_top dut (.clock_i(clk), .resetn_i(rst_n), .serial_clock_i(sclk), .serial_data_i(sdata),
        .latch_load_i(load), .blank_n_i(blank_n), .temp_above_upper_i(hot), .temp_below_lower_i(cool),
        .led_sink_outputs_o(led), .serial_out_o(sout), .event_ready_o(rdy));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // longer than the six-cycle event path
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask : settle
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic t_shift_latch;
        host.send(8'hA5);
        host.load_pulse();
        settle();
        chk("led", 16'(8'hA5), 16'(led));
        chk("sout", 16'h0001, 16'(sout));
        host.send(8'h3C);
        settle();
        chk("led held", 16'(8'hA5), 16'(led));
        chk("sout", 16'h0000, 16'(sout));
        host.load_pulse();
        settle();
        chk("led new", 16'(8'h3C), 16'(led));
        $display("test shift_latch done");
    endtask : t_shift_latch
    // about 30 kHz dimming; a closing blanked phase catches the last on-phase lag
    task automatic t_blank;
        int n;
        n = 0;
        blank_n = 1'b1;
        host.send(8'h81);
        host.load_pulse();
        chk("blanked", 16'h0000, 16'(led));
        for (int k = 0; k < 17; k++) begin
            blank_n = ~k[0];
            repeat (667) begin
                @(negedge clk);
                n += int'(led[0]);
            end
        end
        chk("on cycles", 16'd5336, 16'(n));
        blank_n = 1'b0;
        settle();
        chk("unblanked", 16'(8'h81), 16'(led));
        $display("test blank done");
    endtask : t_blank
    task automatic t_thermal;
        hot = 1'b1;
        cool = 1'b0;
        settle();
        chk("hot", 16'h0000, 16'(led));
        hot = 1'b0;
        settle();
        chk("hysteresis", 16'h0000, 16'(led));
        cool = 1'b1;
        settle();
        chk("restored", 16'(8'h81), 16'(led));
        $display("test thermal done");
    endtask : t_thermal
    task automatic t_standalone;
        host.hold_load(1'b1);
        host.send(8'hFF);
        settle();
        chk("standalone", 16'(8'hFF), 16'(led));
        host.hold_load(1'b0);
        $display("test standalone done");
    endtask : t_standalone
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        blank_n = 1'b1;
        hot = 1'b0;
        cool = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        blank_n = 1'b0;
        t_shift_latch();
        t_blank();
        t_thermal();
        t_standalone();
        report_and_stop();
    end
endmodule : tb_top
